// ### homing_regs.vh
// Object indices, field positions, method codes and timing for the homing
// sequencer. Assumes a 200 MHz drive clock and an object dictionary port.
`ifndef HOMING_REGS_VH
`define HOMING_REGS_VH

`define OBJ_CONTROL 16'h6040
`define OBJ_STATUS 16'h6041
`define OBJ_MODE 16'h6060
`define OBJ_HOME_OFFSET 16'h607C
`define OBJ_METHOD 16'h6098
`define OBJ_DWELL_MS 16'h2F00
`define OBJ_TRACK_WIN 16'h2F01
`define OBJ_STEPPER 16'h2F02

`define MODE_HOMING 8'h06
`define CTRL_START_BIT 4
`define STAT_ATTAINED_BIT 12
`define STAT_ERROR_BIT 13
`define STAT_BUSY_BIT 14

`define RST_METHOD 8'h00
`define RST_DWELL_MS 16'h0064
`define RST_TRACK_WIN 32'h0000_0100

`define CLOCK_HZ 200000000
`define CYC_PER_MS (`CLOCK_HZ / 1000)

// Method codes as 8-bit two's complement
`define HM_HARD_POS 8'hFF
`define HM_HARD_NEG 8'hFE
`define HM_HARD_NEG_IDX 8'hFD
`define HM_HARD_POS_IDX 8'hFC
`define HM_SW_POS 8'h13
`define HM_SW_NEG 8'h15
`define HM_SW_OUT_POS 8'h03
`define HM_SW_OUT_NEG 8'h05
`define HM_SW_IN_POS 8'h04
`define HM_SW_IN_NEG 8'h06
`define HM_LOW_POS 8'h17
`define HM_LOW_NEG 8'h1D
`define HM_UP_POS 8'h19
`define HM_UP_NEG 8'h1B
`define HM_LOW_OUT_POS 8'h07
`define HM_LOW_OUT_NEG 8'h0E
`define HM_LOW_IN_POS 8'h08
`define HM_LOW_IN_NEG 8'h0D

// Decoded method fields
`define F_VALID 7
`define F_KIND_HI 6
`define F_KIND_LO 5
`define F_START_POS 4
`define F_USE_INDEX 3
`define F_INDEX_POS 2
`define F_FALL_EDGE 1
`define F_NEG_ERR 0
`define KIND_HARD 2'h0
`define KIND_SWITCH 2'h1
`define KIND_MOMENT 2'h2

`endif

// ### input_sync.v
// Two-flop synchroniser for a group of pin inputs.
// Assumes the pins are asynchronous to clock.
`timescale 1ns/1ps
module input_sync #(
  parameter WIDTH = 4
) (
  input wire clock,
  input wire reset,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge clock) begin
        if (reset) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
        end else begin
          meta_q[i] <= async_in[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate
  assign sync_out = sync_q;
endmodule

// ### homing_sequence_control.v
// Homing sequencer: hard-stop, home-switch and momentary-switch methods.
// Assumes one drive clock, asynchronous switch and index pins, and same-clock
// current-limit and following-error inputs from the drive loops.
`timescale 1ns/1ps
`include "homing_regs.vh"
module homing_sequence_control #(
  parameter CYC_PER_MS = `CYC_PER_MS
) (
  input wire clock,
  input wire reset,
  input wire od_write,
  input wire od_read,
  input wire [15:0] od_index,
  input wire [31:0] od_wdata,
  output reg [31:0] od_rdata,
  output reg od_ack,
  output reg od_unknown,
  input wire pos_limit_pin,
  input wire neg_limit_pin,
  input wire home_switch_pin,
  input wire index_pin,
  input wire current_limit_active,
  input wire [31:0] following_error,
  input wire [31:0] actual_position,
  output reg move_active,
  output reg move_positive,
  output reg move_slow,
  output reg homing_done,
  output reg homing_error,
  output reg [15:0] status_word,
  output reg [31:0] zero_position
);

  ////////////////////////////////////////////////////////////////////////
  localparam ST_IDLE = 3'd0;
  localparam ST_SEEK = 3'd1;
  localparam ST_INDEX = 3'd2;
  localparam ST_DONE = 3'd3;
  localparam ST_FAIL = 3'd4;

  function [7:0] method_fields;
    input [7:0] m;
    begin
      case (m)
        `HM_HARD_POS: method_fields = 8'b1001_0000;
        `HM_HARD_NEG: method_fields = 8'b1000_0000;
        `HM_HARD_POS_IDX: method_fields = 8'b1001_1000;
        `HM_HARD_NEG_IDX: method_fields = 8'b1000_1100;
        `HM_SW_POS: method_fields = 8'b1011_0000;
        `HM_SW_NEG: method_fields = 8'b1010_0000;
        `HM_SW_OUT_POS: method_fields = 8'b1011_1000;
        `HM_SW_OUT_NEG: method_fields = 8'b1010_1100;
        `HM_SW_IN_POS: method_fields = 8'b1011_1100;
        `HM_SW_IN_NEG: method_fields = 8'b1010_1000;
        `HM_LOW_POS: method_fields = 8'b1101_0010;
        `HM_LOW_NEG: method_fields = 8'b1100_0010;
        `HM_UP_POS: method_fields = 8'b1101_0000;
        `HM_UP_NEG: method_fields = 8'b1100_0000;
        `HM_LOW_OUT_POS: method_fields = 8'b1101_1010;
        `HM_LOW_OUT_NEG: method_fields = 8'b1100_1011;
        `HM_LOW_IN_POS: method_fields = 8'b1101_1110;
        `HM_LOW_IN_NEG: method_fields = 8'b1100_1111;
        default: method_fields = 8'h00;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  wire [3:0] pins_s;
  input_sync #(
    .WIDTH(4)
  ) u_sync (
    .clock(clock),
    .reset(reset),
    .async_in({index_pin, home_switch_pin, neg_limit_pin, pos_limit_pin}),
    .sync_out(pins_s)
  );
  wire pos_lim = pins_s[0];
  wire neg_lim = pins_s[1];
  wire home_sw = pins_s[2];
  wire index_s = pins_s[3];
  reg [3:0] pins_prev_q;
  wire pos_rise = pos_lim & ~pins_prev_q[0];
  wire neg_rise = neg_lim & ~pins_prev_q[1];
  wire home_rise = home_sw & ~pins_prev_q[2];
  wire home_fall = ~home_sw & pins_prev_q[2];
  wire index_rise = index_s & ~pins_prev_q[3];

  ////////////////////////////////////////////////////////////////////////
  // Objects
  reg [15:0] control_q;
  reg [7:0] mode_q;
  reg [7:0] method_q;
  reg [31:0] offset_q;
  reg [15:0] dwell_ms_q;
  reg [31:0] track_win_q;
  reg stepper_q;
  reg start_prev_q;

  wire start_bit = control_q[`CTRL_START_BIT];
  wire homing_mode = (mode_q == `MODE_HOMING);
  wire start_req = start_bit & ~start_prev_q & homing_mode;

  always @(posedge clock) begin
    if (reset) begin
      control_q <= 16'h0000;
      mode_q <= 8'h00;
      method_q <= `RST_METHOD;
      offset_q <= 32'h0000_0000;
      dwell_ms_q <= `RST_DWELL_MS;
      track_win_q <= `RST_TRACK_WIN;
      stepper_q <= 1'b0;
      start_prev_q <= 1'b0;
      od_rdata <= 32'h0000_0000;
      od_ack <= 1'b0;
      od_unknown <= 1'b0;
    end else begin
      start_prev_q <= start_bit;
      od_ack <= od_write | od_read;
      od_unknown <= 1'b0;
      if (od_write) begin
        case (od_index)
          `OBJ_CONTROL: control_q <= od_wdata[15:0];
          `OBJ_MODE: mode_q <= od_wdata[7:0];
          `OBJ_METHOD: method_q <= od_wdata[7:0];
          `OBJ_HOME_OFFSET: offset_q <= od_wdata;
          `OBJ_DWELL_MS: dwell_ms_q <= od_wdata[15:0];
          `OBJ_TRACK_WIN: track_win_q <= od_wdata;
          `OBJ_STEPPER: stepper_q <= od_wdata[0];
          default: od_unknown <= 1'b1;
        endcase
      end else if (od_read) begin
        case (od_index)
          `OBJ_CONTROL: od_rdata <= {16'h0000, control_q};
          `OBJ_STATUS: od_rdata <= {16'h0000, status_word};
          `OBJ_MODE: od_rdata <= {24'h00_0000, mode_q};
          `OBJ_METHOD: od_rdata <= {{24{method_q[7]}}, method_q};
          `OBJ_HOME_OFFSET: od_rdata <= offset_q;
          `OBJ_DWELL_MS: od_rdata <= {16'h0000, dwell_ms_q};
          `OBJ_TRACK_WIN: od_rdata <= track_win_q;
          `OBJ_STEPPER: od_rdata <= {31'h0000_0000, stepper_q};
          default: begin
            od_rdata <= 32'h0000_0000;
            od_unknown <= 1'b1;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Hard stop detection
  reg [31:0] ms_cyc_q;
  reg [15:0] ms_cnt_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  wire seeking = (state_q == ST_SEEK);
  wire ms_tick = (ms_cyc_q == CYC_PER_MS - 1);
  wire [31:0] ferr_neg = ~following_error + 32'h0000_0001;
  wire [31:0] ferr_abs = following_error[31] ? ferr_neg : following_error;
  wire servo_stop = (ms_cnt_q >= dwell_ms_q) & current_limit_active;
  wire stepper_stop = ferr_abs > track_win_q;
  wire stop_hit = stepper_q ? stepper_stop : servo_stop;

  // Any dip in the current limit restarts the dwell from zero
  always @(posedge clock) begin
    if (reset) begin
      ms_cyc_q <= 32'h0000_0000;
      ms_cnt_q <= 16'h0000;
    end else if (!seeking || !current_limit_active) begin
      ms_cyc_q <= 32'h0000_0000;
      ms_cnt_q <= 16'h0000;
    end else if (ms_tick) begin
      ms_cyc_q <= 32'h0000_0000;
      if (ms_cnt_q != 16'hFFFF) begin
        ms_cnt_q <= ms_cnt_q + 16'h0001;
      end
    end else begin
      ms_cyc_q <= ms_cyc_q + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  reg [7:0] fields_q;
  reg dir_q;
  reg dir_d;
  reg rev_q;
  reg rev_d;
  reg home_start_q;
  reg capture;
  reg fail;
  wire [7:0] fields_new = method_fields(method_q);
  wire [1:0] kind = fields_q[`F_KIND_HI:`F_KIND_LO];
  wire lim_ahead = dir_q ? pos_lim : neg_lim;
  wire lim_ahead_rise = dir_q ? pos_rise : neg_rise;
  wire err_lim = fields_q[`F_NEG_ERR] ? neg_rise : lim_ahead_rise;
  wire mom_edge = fields_q[`F_FALL_EDGE] ? home_fall : home_rise;
  wire new_is_switch = (fields_new[`F_KIND_HI:`F_KIND_LO] == `KIND_SWITCH);

  always @* begin
    state_d = state_q;
    dir_d = dir_q;
    rev_d = rev_q;
    capture = 1'b0;
    fail = 1'b0;
    case (state_q)
      ST_IDLE, ST_DONE, ST_FAIL: begin
        if (start_req) begin
          rev_d = 1'b0;
          if (!fields_new[`F_VALID]) begin
            state_d = ST_FAIL;
            fail = 1'b1;
          end else begin
            state_d = ST_SEEK;
            // Switch already active means home lies behind
            dir_d = fields_new[`F_START_POS] ^ (new_is_switch & home_sw);
          end
        end
      end
      ST_SEEK: begin
        case (kind)
          `KIND_HARD: begin
            if (lim_ahead) begin
              fail = 1'b1;
            end else if (stop_hit) begin
              capture = 1'b1;
            end
          end
          `KIND_SWITCH: begin
            if (pos_lim | neg_lim) begin
              fail = 1'b1;
            end else if (home_sw != home_start_q) begin
              capture = 1'b1;
            end
          end
          `KIND_MOMENT: begin
            if (mom_edge) begin
              capture = 1'b1;
            end else if (!rev_q && lim_ahead) begin
              dir_d = ~dir_q;
              rev_d = 1'b1;
            end else if (rev_q && err_lim) begin
              fail = 1'b1;
            end
          end
          default: fail = 1'b1;
        endcase
        if (fail) begin
          state_d = ST_FAIL;
        end else if (capture && fields_q[`F_USE_INDEX]) begin
          state_d = ST_INDEX;
          capture = 1'b0;
          dir_d = fields_q[`F_INDEX_POS];
        end else if (capture) begin
          state_d = ST_DONE;
        end
      end
      ST_INDEX: begin
        if (index_rise) begin
          capture = 1'b1;
          state_d = ST_DONE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    // Dropping the start bit or leaving homing mode aborts a move
    if ((state_q == ST_SEEK || state_q == ST_INDEX) &&
        (!start_bit || !homing_mode)) begin
      state_d = ST_IDLE;
      capture = 1'b0;
      fail = 1'b0;
    end
  end

  always @(posedge clock) begin
    if (reset) begin
      state_q <= ST_IDLE;
      fields_q <= 8'h00;
      dir_q <= 1'b0;
      rev_q <= 1'b0;
      home_start_q <= 1'b0;
      pins_prev_q <= 4'h0;
      move_active <= 1'b0;
      move_positive <= 1'b0;
      move_slow <= 1'b0;
      homing_done <= 1'b0;
      homing_error <= 1'b0;
      status_word <= 16'h0000;
      zero_position <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      dir_q <= dir_d;
      rev_q <= rev_d;
      pins_prev_q <= pins_s;
      if (start_req) begin
        fields_q <= fields_new;
        home_start_q <= home_sw;
      end
      if (capture) begin
        zero_position <= actual_position + offset_q;
      end
      move_active <= (state_d == ST_SEEK) | (state_d == ST_INDEX);
      move_positive <= dir_d;
      move_slow <= (state_d == ST_INDEX);
      homing_done <= (state_d == ST_DONE);
      homing_error <= (state_d == ST_FAIL);
      status_word <= 16'h0000;
      status_word[`STAT_ATTAINED_BIT] <= (state_d == ST_DONE);
      status_word[`STAT_ERROR_BIT] <= (state_d == ST_FAIL);
      status_word[`STAT_BUSY_BIT] <= (state_d == ST_SEEK) |
                                     (state_d == ST_INDEX);
    end
  end

endmodule

// ### homing_checker_sva.sv
// Port checker for the homing sequencer.
// Assumes it is bound onto every homing_sequence_control instance.
`timescale 1ns/1ps
`include "homing_regs.vh"
module homing_checker #(
  parameter CYC_PER_MS = 10
) (
  input wire clock,
  input wire reset,
  input wire od_write,
  input wire od_read,
  input wire od_ack,
  input wire od_unknown,
  input wire move_active,
  input wire move_slow,
  input wire homing_done,
  input wire homing_error,
  input wire [15:0] status_word,
  input wire [31:0] zero_position
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////
  sequence s_req;
    od_write || od_read;
  endsequence
  sequence s_ack;
    od_ack;
  endsequence
  a_ack_follows:
    assert property (s_req |=> s_ack)
    else $error("no acknowledge after strobe");
  a_ack_caused:
    assert property (s_ack |-> $past(od_write || od_read))
    else $error("acknowledge without strobe");
  a_unknown_acked:
    assert property (od_unknown |-> od_ack)
    else $error("unknown flag outside acknowledge");
  a_flags_exclusive:
    assert property (!(homing_done && homing_error))
    else $error("done and error together");
  a_status_mirror:
    assert property (status_word[`STAT_ATTAINED_BIT] == homing_done &&
      status_word[`STAT_ERROR_BIT] == homing_error)
    else $error("status bits disagree with flags");
  a_error_halts:
    assert property (homing_error |-> !move_active)
    else $error("motion after error");
  a_done_halts:
    assert property (homing_done |-> !move_active && !move_slow)
    else $error("motion after home found");
  a_zero_on_done:
    assert property (!$stable(zero_position) |-> $rose(homing_done))
    else $error("zero moved without completion");
  a_slow_moving:
    assert property (move_slow |-> move_active)
    else $error("slow phase without motion");
endmodule

bind homing_sequence_control homing_checker #(.CYC_PER_MS(CYC_PER_MS))
  homing_checker_inst (.clock(clock), .reset(reset),
  .od_write(od_write), .od_read(od_read), .od_ack(od_ack),
  .od_unknown(od_unknown), .move_active(move_active),
  .move_slow(move_slow), .homing_done(homing_done),
  .homing_error(homing_error), .status_word(status_word),
  .zero_position(zero_position));

// ### axis_model.sv
// Axis model: position, limit, home and index pins, hard stops.
// Assumes one step of travel per clock while motion is commanded.
`timescale 1ns/1ps
module axis_model (
  input wire clock,
  input wire load,
  input wire [31:0] load_pos,
  input wire lim_en,
  input wire sw_en,
  input wire cl_en,
  input wire move_active,
  input wire move_positive,
  output logic pos_limit_pin,
  output logic neg_limit_pin,
  output logic home_switch_pin,
  output logic index_pin,
  output logic current_limit_active,
  output logic signed [31:0] pos = '0
);
  localparam int STOP = 60;
  localparam int LIM = 50;
  // Stops lie beyond the limits, so hard stops need limits off
  wire at_stop = move_positive ? pos >= STOP : pos <= -STOP;
  always @(posedge clock) begin
    if (load)
      pos <= load_pos;
    else if (move_active && !at_stop)
      pos <= move_positive ? pos + 1 : pos - 1;
  end
  assign pos_limit_pin = lim_en && pos >= LIM;
  assign neg_limit_pin = lim_en && pos <= -LIM;
  assign home_switch_pin = sw_en && pos >= 10 && pos <= 20;
  assign index_pin = pos[3:0] == 4'h0;
  assign current_limit_active = cl_en && move_active && at_stop;
endmodule

// ### testbench.sv
// Self-checking bench: object writes start homing runs on a model axis.
// Assumes a scaled millisecond of 10 clocks and dwell set to 1 ms.
`timescale 1ns/1ps
`include "homing_regs.vh"
module testbench;
  logic clock = 0, reset = 1, od_write = 0, od_read = 0, unk;
  logic load = 0, lim_en = 0, sw_en = 1, cl_en = 1;
  logic [15:0] od_index = '0;
  logic [31:0] od_wdata = '0, load_pos = '0, rd;
  logic [31:0] following_error = 32'h0000_0100;
  wire [31:0] od_rdata, zero_position, actual_position;
  wire [15:0] status_word;
  wire od_ack, od_unknown, pos_lim, neg_lim, home_sw, index_pulse, cur_lim;
  wire move_active, move_positive, move_slow, homing_done, homing_error;
  localparam logic [31:0] OFS = 32'h0000_0100;
  int fails = 0, compares = 0, cl_run = 0;
  homing_sequence_control #(.CYC_PER_MS(10)) homing_sequence_control_inst (
    .clock(clock), .reset(reset), .od_write(od_write), .od_read(od_read),
    .od_index(od_index), .od_wdata(od_wdata), .od_rdata(od_rdata),
    .od_ack(od_ack), .od_unknown(od_unknown), .pos_limit_pin(pos_lim),
    .neg_limit_pin(neg_lim), .home_switch_pin(home_sw),
    .index_pin(index_pulse), .current_limit_active(cur_lim),
    .following_error(following_error), .actual_position(actual_position),
    .move_active(move_active), .move_positive(move_positive),
    .move_slow(move_slow), .homing_done(homing_done),
    .homing_error(homing_error), .status_word(status_word),
    .zero_position(zero_position));
  axis_model axis_model_inst (.clock(clock), .load(load),
    .load_pos(load_pos), .lim_en(lim_en), .sw_en(sw_en), .cl_en(cl_en),
    .move_active(move_active), .move_positive(move_positive),
    .pos_limit_pin(pos_lim), .neg_limit_pin(neg_lim),
    .home_switch_pin(home_sw), .index_pin(index_pulse),
    .current_limit_active(cur_lim), .pos(actual_position));
  initial forever #2.5 clock = ~clock;
  // Length of the last unbroken current-limit stretch
  always @(posedge clock) begin
    if (cur_lim)
      cl_run <= cl_run + 1;
    else if (move_active)
      cl_run <= 0;
  end
  ////////////////////////////////////////
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic obj(input logic wr, input logic [15:0] idx,
      input logic [31:0] d);
    @(posedge clock);
    od_write <= wr;
    od_read <= !wr;
    od_index <= idx;
    od_wdata <= d;
    @(posedge clock);
    od_write <= 0;
    od_read <= 0;
    #1;
    chk(od_ack, 1);
    rd = od_rdata;
    unk = od_unknown;
  endtask
  task automatic start_run(input logic [7:0] m, input logic [31:0] p,
      input logic le, input logic dir);
    load <= 1;
    load_pos <= p;
    lim_en <= le;
    obj(1, `OBJ_CONTROL, '0);
    load <= 0;
    obj(1, `OBJ_METHOD, {24'h00_0000, m});
    obj(1, `OBJ_CONTROL, 32'h0000_0010);
    // Motion answers one edge after the start is seen
    @(posedge clock);
    #1;
    if (move_active === 1)
      chk(move_positive, dir);
  endtask
  task automatic end_run(input logic err);
    int n;
    logic [31:0] z;
    n = 0;
    z = zero_position;
    while (homing_done !== 1 && homing_error !== 1) begin
      @(posedge clock);
      #1;
      n++;
      if (n > 3000) begin
        fails++;
        tally_and_finish();
      end
    end
    chk({homing_done, homing_error}, {!err, err});
    chk(status_word[14:12], {1'b0, err, !err});
    if (err)
      chk(zero_position, z);
  endtask
  task automatic wait_slow(input logic dir);
    int n;
    n = 0;
    while (move_slow !== 1) begin
      @(posedge clock);
      #1;
      n++;
      if (n > 3000) begin
        fails++;
        tally_and_finish();
      end
    end
    chk(move_positive, dir);
  endtask
  task automatic home_run(input logic [7:0] m, input logic [31:0] p,
      input logic le, input logic err, input logic dir);
    start_run(m, p, le, dir);
    end_run(err);
  endtask
  ////////////////////////////////////////
  task automatic test_objects();
    obj(0, `OBJ_METHOD, '0);
    chk(rd, '0);
    obj(1, `OBJ_METHOD, 32'h0000_00FE);
    obj(0, `OBJ_METHOD, '0);
    chk(rd, 32'hFFFF_FFFE);
    obj(1, `OBJ_STATUS, '0);
    chk(unk, 1);
    obj(0, 16'h1234, '0);
    chk(unk, 1);
    chk(rd, '0);
    obj(1, `OBJ_MODE, 32'h0000_0006);
    obj(1, `OBJ_DWELL_MS, 32'h0000_0001);
    obj(1, `OBJ_HOME_OFFSET, OFS);
    $display("test_objects finished");
  endtask
  task automatic test_hard_stop();
    home_run(`HM_HARD_POS, '0, 0, 0, 1);
    chk(zero_position, 32'h0000_003C + OFS);
    chk(cl_run >= 10 && cl_run <= 22, 1);
    home_run(`HM_HARD_NEG, '0, 0, 0, 0);
    chk(zero_position, 32'hFFFF_FFC4 + OFS);
    start_run(`HM_HARD_POS_IDX, '0, 0, 1);
    wait_slow(0);
    end_run(0);
    chk(zero_position, 32'h0000_002E + OFS);
    start_run(`HM_HARD_NEG_IDX, '0, 0, 0);
    wait_slow(1);
    end_run(0);
    chk(zero_position, 32'hFFFF_FFD2 + OFS);
    home_run(`HM_HARD_POS, '0, 1, 1, 1);
    home_run(`HM_HARD_NEG, '0, 1, 1, 0);
    $display("test_hard_stop finished");
  endtask
  task automatic test_switch();
    home_run(`HM_SW_POS, '0, 1, 0, 1);
    home_run(`HM_SW_POS, 32'h0000_000F, 1, 0, 0);
    home_run(`HM_SW_POS, 32'h0000_001E, 1, 1, 1);
    home_run(`HM_SW_NEG, 32'h0000_001E, 1, 0, 0);
    home_run(`HM_SW_OUT_POS, '0, 1, 0, 1);
    home_run(`HM_SW_OUT_NEG, 32'h0000_001E, 1, 0, 0);
    home_run(`HM_SW_IN_POS, '0, 1, 0, 1);
    home_run(`HM_SW_IN_NEG, 32'h0000_001E, 1, 0, 0);
    $display("test_switch finished");
  endtask
  task automatic test_moment();
    home_run(`HM_LOW_POS, 32'h0000_001E, 1, 0, 1);
    home_run(`HM_LOW_NEG, '0, 1, 0, 0);
    home_run(`HM_UP_POS, 32'h0000_001E, 1, 0, 1);
    home_run(`HM_UP_NEG, '0, 1, 0, 0);
    home_run(`HM_LOW_OUT_POS, 32'h0000_001E, 1, 0, 1);
    home_run(`HM_LOW_OUT_NEG, '0, 1, 0, 0);
    home_run(`HM_LOW_IN_POS, 32'h0000_001E, 1, 0, 1);
    home_run(`HM_LOW_IN_NEG, '0, 1, 0, 0);
    sw_en <= 0;
    home_run(`HM_LOW_POS, 32'h0000_001E, 1, 1, 1);
    home_run(`HM_LOW_NEG, '0, 1, 1, 0);
    sw_en <= 1;
    $display("test_moment finished");
  endtask
  task automatic test_stepper();
    cl_en <= 0;
    obj(1, `OBJ_STEPPER, 32'h0000_0001);
    start_run(`HM_HARD_POS, '0, 0, 1);
    // Error equal to the window must not count as a stop
    repeat (100) @(posedge clock);
    #1;
    chk(homing_done, 0);
    following_error <= 32'h0000_0101;
    end_run(0);
    chk(zero_position, 32'h0000_003C + OFS);
    following_error <= 32'h0000_0100;
    cl_en <= 1;
    obj(1, `OBJ_STEPPER, '0);
    $display("test_stepper finished");
  endtask
  task automatic test_refusal();
    home_run(8'h0F, '0, 0, 1, 0);
    start_run(`HM_HARD_POS, '0, 0, 1);
    obj(1, `OBJ_CONTROL, '0);
    repeat (2) @(posedge clock);
    #1;
    chk({move_active, homing_done, homing_error}, '0);
    obj(1, `OBJ_MODE, 32'h0000_0003);
    start_run(`HM_HARD_POS, '0, 0, 1);
    chk(move_active, 0);
    obj(1, `OBJ_MODE, 32'h0000_0006);
    $display("test_refusal finished");
  endtask
  initial begin
    repeat (8) @(posedge clock);
    reset <= 0;
    test_objects();
    test_hard_stop();
    test_switch();
    test_moment();
    test_stepper();
    test_refusal();
    tally_and_finish();
  end
endmodule
